// ==== verilog/sysm_top.sv ====
// Purpose: sensor input sync, mode and write-gate setup with APB registers
// Assumes: pixel inputs synchronous to pclk; ce low freezes all state
// Notes: pin output enables are active low; APB answers with no wait state
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sysm_top
    import sysm_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int PIX_W = 16
)
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pixel input
    input wire logic [PIX_W-1:0] pix_in,
    input wire logic pix_valid,
    input wire logic ext_write_gate,
    // sync pins: 0 line, 1 frame, 2 field
    input wire logic [2:0] sync_pin_i,
    output logic [2:0] sync_pin_o,
    output logic [2:0] sync_pin_oe_n,
    // memory write path
    output logic [PIX_W-1:0] mem_data,
    output logic mem_valid,
    output logic mem_byte_mode
);
    // raw sample width code to mask of the valid low bits
    function automatic logic [15:0] width_mask(input logic [2:0] code);
        unique case (code)
            3'h0: width_mask = 16'hFFFF;
            3'h1: width_mask = 16'h7FFF;
            3'h2: width_mask = 16'h3FFF;
            3'h3: width_mask = 16'h1FFF;
            3'h4: width_mask = 16'h0FFF;
            3'h5: width_mask = 16'h07FF;
            3'h6: width_mask = 16'h03FF;
            3'h7: width_mask = 16'h00FF;
        endcase
    endfunction
    // right shift that leaves the top eight sample bits
    function automatic logic [3:0] width_shift(input logic [2:0] code);
        width_shift = (code == 3'h7) ? 4'h0 : 4'h8 - {1'b0, code};
    endfunction

    logic [31:0] setup_reg;
    logic [31:0] widths_reg;
    logic [31:0] timing_reg;
    logic hs_gen;
    logic vs_gen;
    logic field_gen;

    // register fields
    wire tg_en = setup_reg[SYSM_B_TG_EN];
    wire [1:0] mode = setup_reg[SYSM_B_MODE_LO +: 2];
    wire pack = setup_reg[SYSM_B_PACK];
    wire [2:0] wcode = setup_reg[SYSM_B_WIDTH_LO +: 3];
    wire interlace = setup_reg[SYSM_B_INTERLACE];
    wire invert = setup_reg[SYSM_B_INVERT];
    wire ext_gate_sel = setup_reg[SYSM_B_EXT_GATE];
    wire sync_dir = setup_reg[SYSM_B_SYNC_DIR];
    wire field_dir = setup_reg[SYSM_B_FIELD_DIR];
    wire [2:0] pin_pol = {setup_reg[SYSM_B_FIELD_POL], setup_reg[SYSM_B_FRAME_POL],
        setup_reg[SYSM_B_LINE_POL]};
    wire [2:0] pin_dir = {field_dir, sync_dir, sync_dir};
    wire [2:0] pin_int = {field_gen, vs_gen, hs_gen};
    wire [2:0] pin_in_int;

    // polarity and direction per sync pin
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_pin
            assign sync_pin_o[g] = pin_int[g] ^ pin_pol[g];
            assign sync_pin_oe_n[g] = !pin_dir[g];
            assign pin_in_int[g] = sync_pin_i[g] ^ pin_pol[g];
        end
    endgenerate

    // field seen by software: zero unless interlaced, then own toggle when driving, pin otherwise
    wire field_now = interlace && (field_dir ? field_gen : pin_in_int[SYSM_PIN_FIELD]);

    // apb decode
    wire hit_setup = paddr == SYSM_OFF_SETUP[ADDR_W-1:0];
    wire hit_widths = paddr == SYSM_OFF_WIDTHS[ADDR_W-1:0];
    wire hit_timing = paddr == SYSM_OFF_TIMING[ADDR_W-1:0];
    wire hit_any = hit_setup || hit_widths || hit_timing;
    wire apb_setup = ce && psel && !penable;
    wire apb_wr = ce && psel && penable && pwrite;
    wire [31:0] rd_mux = hit_setup ? ((setup_reg & SYSM_MASK_SETUP)
        | ({31'h0, field_now} << SYSM_B_FIELD_STAT)) :
        hit_widths ? widths_reg : hit_timing ? timing_reg : 32'h0000_0000;

    assign pready = ce;
    assign pslverr = psel && penable && !hit_any;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            setup_reg <= SYSM_RST_SETUP;
            widths_reg <= SYSM_RST_WIDTHS;
            timing_reg <= SYSM_RST_TIMING;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            if (apb_setup && !pwrite)
                prdata <= rd_mux;
            if (apb_wr && hit_setup)
                setup_reg <= pwdata & SYSM_MASK_SETUP;
            if (apb_wr && hit_widths)
                widths_reg <= pwdata & SYSM_MASK_WIDTHS;
            if (apb_wr && hit_timing)
                timing_reg <= pwdata;
        end
    end

    // widths only take effect in the generator when driving syncs
    sysm_syncgen u_syncgen (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tg_en(tg_en),
        .sync_drive(sync_dir),
        .interlace(interlace),
        .ppl(timing_reg[SYSM_B_PPL_LO +: 16]),
        .lpf(timing_reg[SYSM_B_LPF_LO +: 16]),
        .line_w(widths_reg[SYSM_B_LINE_W_LO +: 12]),
        .frame_w(widths_reg[SYSM_B_FRAME_W_LO +: 12]),
        .hs_in(pin_in_int[SYSM_PIN_LINE]),
        .vs_in(pin_in_int[SYSM_PIN_FRAME]),
        .hs_reg(hs_gen),
        .vs_reg(vs_gen),
        .field_reg(field_gen)
    );

    // raw sample width mask then optional complement
    wire [15:0] mask = width_mask(wcode);
    wire [15:0] raw_smp = (pix_in & mask) ^ (invert ? mask : 16'h0000);
    wire [15:0] raw_byte = raw_smp >> width_shift(wcode);
    // mode decode; reserved mode writes nothing
    wire is_raw = mode == SYSM_MODE_RAW;
    wire is_yc8 = mode == SYSM_MODE_YC8;
    wire mode_ok = mode != SYSM_MODE_RSVD;
    wire [15:0] smp = is_raw ? raw_smp : (is_yc8 ? {8'h00, pix_in[7:0]} : pix_in);
    // byte packing keeps the top eight bits of a raw sample
    wire [15:0] smp_out = !pack ? smp : (is_raw ? {8'h00, raw_byte[7:0]} :
        {8'h00, smp[7:0]});
    // external gate only counts with generator enabled
    wire gate_used = ext_gate_sel && tg_en;
    wire write_now = pix_valid && mode_ok && (!gate_used || ext_write_gate);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_data <= '0;
            mem_valid <= 1'b0;
            mem_byte_mode <= 1'b0;
        end
        else if (ce)
        begin
            mem_valid <= write_now;
            mem_byte_mode <= pack;
            if (write_now)
                mem_data <= smp_out[PIX_W-1:0];
        end
    end

    property p_gate_blocks;
        @(posedge pclk) disable iff (!presetn)
        ce && gate_used && !ext_write_gate |=> !mem_valid;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks)
        else $error("write passed with external gate low");
    property p_gate_ignored;
        @(posedge pclk) disable iff (!presetn)
        ce && !ext_gate_sel && pix_valid && is_raw |=> mem_valid;
    endproperty
    a_gate_ignored: assert property (p_gate_ignored)
        else $error("raw sample dropped with gate select clear");
    property p_pack_mode;
        @(posedge pclk) disable iff (!presetn)
        ce && write_now && pack |=> mem_byte_mode && mem_data[15:8] == 8'h00;
    endproperty
    a_pack_mode: assert property (p_pack_mode)
        else $error("packed pixel wider than eight bits");
    property p_width_8;
        @(posedge pclk) disable iff (!presetn)
        ce && write_now && is_raw && wcode == 3'h7 |=> mem_data[15:8] == 8'h00;
    endproperty
    a_width_8: assert property (p_width_8)
        else $error("eight-bit raw sample has high bits set");
    property p_invert;
        @(posedge pclk) disable iff (!presetn)
        ce && write_now && is_raw && invert && !pack && wcode == 3'h0
            |=> mem_data == ~$past(pix_in);
    endproperty
    a_invert: assert property (p_invert)
        else $error("raw sample not complemented");
    property p_pin_drive;
        @(posedge pclk) disable iff (!presetn)
        sync_dir |-> !sync_pin_oe_n[SYSM_PIN_LINE]
            && sync_pin_o[SYSM_PIN_LINE] == (hs_gen ^ pin_pol[SYSM_PIN_LINE]);
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("line sync pin not driven with polarity");
    property p_pin_input;
        @(posedge pclk) disable iff (!presetn)
        !sync_dir |-> sync_pin_oe_n[SYSM_PIN_LINE] && sync_pin_oe_n[SYSM_PIN_FRAME];
    endproperty
    a_pin_input: assert property (p_pin_input)
        else $error("sync pins driven while set as inputs");
endmodule
`default_nettype wire

// ==== common/sysm_pkg.sv ====
// Purpose: constants for the sensor sync and mode setup block
// Assumes: 32-bit APB, one word per register
// Notes: offsets are byte addresses
// Behaviour
// - pack bit selects 8 or 16 bits per pixel
// - width code 0..7 gives 16..10, 8 bits
// - gate select and generator on: external gate rules
// - gate select clear ignores external write gate
// - driven line sync lasts width plus one clocks
// - line width ignored when syncs are inputs
// - driven frame sync lasts width plus one lines
// - frame width ignored when syncs are inputs
// - generator enable runs or locks sync timing
package sysm_pkg;
    localparam logic [11:0] SYSM_OFF_SETUP = 12'h000;
    localparam logic [11:0] SYSM_OFF_WIDTHS = 12'h004;
    localparam logic [11:0] SYSM_OFF_TIMING = 12'h008;
    localparam logic [31:0] SYSM_RST_SETUP = 32'h0000_0000;
    localparam logic [31:0] SYSM_RST_WIDTHS = 32'h0000_0000;
    localparam logic [31:0] SYSM_RST_TIMING = 32'h0000_0000;
    localparam logic [31:0] SYSM_MASK_SETUP = 32'h0001_3FFF;
    localparam logic [31:0] SYSM_MASK_WIDTHS = 32'h0FFF_0FFF;
    // setup register field positions
    localparam int SYSM_B_TG_EN = 16;
    localparam int SYSM_B_FIELD_STAT = 15;
    localparam int SYSM_B_MODE_LO = 12;
    localparam int SYSM_B_PACK = 11;
    localparam int SYSM_B_WIDTH_LO = 8;
    localparam int SYSM_B_INTERLACE = 7;
    localparam int SYSM_B_INVERT = 6;
    localparam int SYSM_B_EXT_GATE = 5;
    localparam int SYSM_B_FIELD_POL = 4;
    localparam int SYSM_B_LINE_POL = 3;
    localparam int SYSM_B_FRAME_POL = 2;
    localparam int SYSM_B_FIELD_DIR = 1;
    localparam int SYSM_B_SYNC_DIR = 0;
    // width register and timing register fields
    localparam int SYSM_B_LINE_W_LO = 16;
    localparam int SYSM_B_FRAME_W_LO = 0;
    localparam int SYSM_B_PPL_LO = 16;
    localparam int SYSM_B_LPF_LO = 0;
    // pin index in the three-pin sync group
    localparam int SYSM_PIN_LINE = 0;
    localparam int SYSM_PIN_FRAME = 1;
    localparam int SYSM_PIN_FIELD = 2;
    typedef enum logic [1:0] {
        SYSM_MODE_RAW = 2'h0,
        SYSM_MODE_YC16 = 2'h1,
        SYSM_MODE_YC8 = 2'h2,
        SYSM_MODE_RSVD = 2'h3
    } sysm_mode_t;
endpackage

// ==== verilog/sysm_syncgen.sv ====
// Purpose: internal line/frame timing generator
// Assumes: widths latched at each frame start
// Notes: pulses start at pixel 0 / line 0 of the generated timing
`timescale 1ns/1ps
`default_nettype none
module sysm_syncgen
    import sysm_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // control
    input wire logic tg_en,
    input wire logic sync_drive,
    input wire logic interlace,
    input wire logic [15:0] ppl,
    input wire logic [15:0] lpf,
    input wire logic [11:0] line_w,
    input wire logic [11:0] frame_w,
    // incoming syncs, active high
    input wire logic hs_in,
    input wire logic vs_in,
    // generated timing
    output logic hs_reg,
    output logic vs_reg,
    output logic field_reg
);
    logic [15:0] pix_reg;
    logic [15:0] line_reg;
    logic [11:0] line_w_reg;
    logic [11:0] frame_w_reg;
    logic hs_in_reg;
    logic vs_in_reg;
    wire hs_edge = hs_in && !hs_in_reg;
    wire vs_edge = vs_in && !vs_in_reg;
    wire line_end = sync_drive ? (pix_reg == ppl) : hs_edge;
    wire frame_end = sync_drive ? (line_end && line_reg == lpf) : vs_edge;
    wire [15:0] pix_next = line_end ? 16'h0000 : pix_reg + 16'h0001;
    wire [15:0] line_next = frame_end ? 16'h0000 : (line_end ? line_reg + 16'h0001 : line_reg);
    wire hs_next = tg_en && sync_drive && (pix_next <= {4'h0, line_w_reg});
    wire vs_next = tg_en && sync_drive && (line_next <= {4'h0, frame_w_reg});

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pix_reg <= 16'h0000;
            line_reg <= 16'h0000;
            hs_reg <= 1'b0;
            vs_reg <= 1'b0;
            hs_in_reg <= 1'b0;
            vs_in_reg <= 1'b0;
            field_reg <= 1'b0;
        end
        else if (ce)
        begin
            hs_in_reg <= hs_in;
            vs_in_reg <= vs_in;
            pix_reg <= tg_en ? pix_next : 16'h0000;
            line_reg <= tg_en ? line_next : 16'h0000;
            hs_reg <= hs_next;
            vs_reg <= vs_next;
            // field toggles per frame when interlaced
            if (!interlace)
                field_reg <= 1'b0;
            else if (tg_en && frame_end)
                field_reg <= !field_reg;
        end
    end

    // new widths taken at frame sync, and on every clock while the generator is off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            line_w_reg <= 12'h000;
            frame_w_reg <= 12'h000;
        end
        else if (ce && (!tg_en || frame_end))
        begin
            line_w_reg <= line_w;
            frame_w_reg <= frame_w;
        end
    end

    sequence s_line_width_end;
        ce && tg_en && sync_drive && hs_reg && pix_reg == {4'h0, line_w_reg}
            && ppl > {4'h0, line_w_reg};
    endsequence
    sequence s_frame_width_end;
        ce && tg_en && sync_drive && line_end && line_reg == {4'h0, frame_w_reg}
            && lpf > {4'h0, frame_w_reg} && !frame_end;
    endsequence

    property p_line_pulse_start;
        @(posedge pclk) disable iff (!presetn)
        ce && tg_en && sync_drive && line_end |=> hs_reg;
    endproperty
    a_line_pulse_start: assert property (p_line_pulse_start)
        else $error("line sync did not start at line end");
    property p_line_pulse_end;
        @(posedge pclk) disable iff (!presetn)
        s_line_width_end |=> !hs_reg;
    endproperty
    a_line_pulse_end: assert property (p_line_pulse_end)
        else $error("line sync longer than width plus one");
    property p_frame_pulse_end;
        @(posedge pclk) disable iff (!presetn)
        s_frame_width_end |=> !vs_reg;
    endproperty
    a_frame_pulse_end: assert property (p_frame_pulse_end)
        else $error("frame sync longer than width plus one lines");
    property p_input_no_drive;
        @(posedge pclk) disable iff (!presetn)
        ce && !sync_drive |=> !hs_reg && !vs_reg;
    endproperty
    a_input_no_drive: assert property (p_input_no_drive)
        else $error("sync pulses generated while syncs are inputs");
    property p_gen_off;
        @(posedge pclk) disable iff (!presetn)
        ce && !tg_en |=> pix_reg == 16'h0000 && line_reg == 16'h0000 && !hs_reg;
    endproperty
    a_gen_off: assert property (p_gen_off)
        else $error("timing generator ran while disabled");
endmodule
`default_nettype wire

// ==== verif/sysm_camera_model.sv ====
// Purpose: camera source model for the sensor sync and mode block
// Assumes: bench hands samples, valid and write gate one per clock
// Notes: idle pixel bus shows the inverse of the last sample
`timescale 1ns/1ps
`default_nettype none
module sysm_camera_model
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench requests
    input wire logic [15:0] cam_data,
    input wire logic cam_valid,
    input wire logic cam_gate,
    // block side
    input wire logic [2:0] pin_o,
    input wire logic [2:0] pin_oe_n,
    output logic [15:0] pix_in,
    output logic pix_valid,
    output logic ext_write_gate,
    output logic [2:0] pin_i
);
    logic [6:0] cnt_reg;
    logic [15:0] last_reg;
    logic [2:0] cam_sync;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= 7'h00;
            last_reg <= 16'h0000;
        end
        else
        begin
            cnt_reg <= (cnt_reg == 7'h63) ? 7'h00 : cnt_reg + 7'h01;
            if (cam_valid)
                last_reg <= cam_data;
        end
    end
    // line every 20 clocks, frame every 5 lines, field held low
    assign cam_sync = {1'b0, cnt_reg < 7'h14, (cnt_reg % 7'h14) < 7'h02};
    // a pin the block drives wins over the sensor's own level
    assign pin_i = (pin_oe_n & cam_sync) | (~pin_oe_n & pin_o);
    // stale data never looks like a repeat of the last sample
    assign pix_in = cam_valid ? cam_data : ~last_reg;
    assign pix_valid = cam_valid;
    assign ext_write_gate = cam_gate;
endmodule
`default_nettype wire

// ==== verif/tb_sensor_sync_mode_config.sv ====
// Purpose: self-checking bench for the sensor sync and mode block
// Assumes: ce held high, APB answers whenever pready is high
// Notes: pixel results compared with an integer model every cycle
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_sync_mode_config import sysm_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] cam_data = 16'h0;
    logic cam_valid = 1'b0;
    logic cam_gate = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, pix_valid, ext_write_gate, mem_valid, mem_byte_mode;
    logic [15:0] pix_in, mem_data;
    logic [2:0] pin_i, pin_o, pin_oe_n;
    logic [31:0] seed = 32'hBB3DFCA4;
    int error_cnt = 0;
    int checks = 0;
    always #5 pclk = ~pclk;
    sysm_top i_sysm_top (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pix_in(pix_in), .pix_valid(pix_valid),
        .ext_write_gate(ext_write_gate), .sync_pin_i(pin_i), .sync_pin_o(pin_o),
        .sync_pin_oe_n(pin_oe_n), .mem_data(mem_data), .mem_valid(mem_valid),
        .mem_byte_mode(mem_byte_mode));
    sysm_camera_model i_sysm_camera_model (.pclk(pclk), .presetn(presetn), .cam_data(cam_data),
        .cam_valid(cam_valid), .cam_gate(cam_gate), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .pix_in(pix_in), .pix_valid(pix_valid), .ext_write_gate(ext_write_gate), .pin_i(pin_i));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            error_cnt++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] model(input logic [31:0] c, input logic [15:0] x);
        int w;
        logic [15:0] m;
        logic [15:0] v;
        w = (c[10:8] == 3'h7) ? 8 : 16 - int'(c[10:8]);
        m = 16'((32'h1 << w) - 1);
        // eight-bit luma/chroma keeps only the low byte of the bus
        v = (c[13:12] == 2'h2) ? (x & 16'h00FF) : x;
        if (c[13:12] == 2'h0)
            v = c[6] ? ((x & m) ^ m) : (x & m);
        if (c[11])
            v = (c[13:12] == 2'h0) ? ((v >> (w - 8)) & 16'h00FF) : (v & 16'h00FF);
        return v;
    endfunction
    // stream random samples under one setup word, checking each result a clock later
    task automatic stream(input logic [31:0] cfg, input int n);
        logic [31:0] r;
        logic e, ev, v, g;
        logic [15:0] ed;
        apb(SYSM_OFF_SETUP, 1'b1, cfg, r, e);
        ev = 1'b0;
        ed = 16'h0000;
        for (int k = 0; k <= n; k++)
        begin
            @(posedge pclk);
            seed = lfsr(seed);
            v = (k < n) && (seed[0] | seed[1]);
            g = seed[2];
            cam_data <= seed[31:16];
            cam_valid <= v;
            cam_gate <= g;
            #1;
            chk("mem_valid", {31'h0, ev}, {31'h0, mem_valid});
            if (ev)
                chk("mem_data", {16'h0, ed}, {16'h0, mem_data});
            ev = v && cfg[13:12] != 2'h3 && !(cfg[5] && cfg[16] && !g);
            ed = model(cfg, seed[31:16]);
        end
        chk("mem_byte_mode", {31'h0, cfg[11]}, {31'h0, mem_byte_mode});
    endtask
    // skip one whole pulse, which may be cut short by enable or polarity change, count the next
    task automatic measure(input int k, input logic act, output int n);
        int g;
        g = 0;
        n = 0;
        while (pin_i[k] !== act && g < 400)
        begin
            @(posedge pclk);
            #1 g++;
        end
        while (pin_i[k] === act && g < 800)
        begin
            @(posedge pclk);
            #1 g++;
        end
        while (pin_i[k] !== act && g < 1200)
        begin
            @(posedge pclk);
            #1 g++;
        end
        while (pin_i[k] === act && n < 400)
        begin
            @(posedge pclk);
            #1 n++;
        end
    endtask
    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        $display("watchdog expired");
        print_verdict();
    end
    initial
    begin
        logic [31:0] r;
        logic e;
        int n;
        logic [31:0] c;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(SYSM_OFF_SETUP, 1'b0, 32'h0, r, e);
        chk("setup_reset", SYSM_RST_SETUP, r);
        apb(SYSM_OFF_WIDTHS, 1'b0, 32'h0, r, e);
        chk("widths_reset", SYSM_RST_WIDTHS, r);
        apb(SYSM_OFF_SETUP, 1'b1, 32'hFFFF_BF7F, r, e);
        apb(SYSM_OFF_SETUP, 1'b0, 32'h0, r, e);
        chk("setup_rw", 32'h0001_3F7F, r);
        apb(SYSM_OFF_WIDTHS, 1'b1, 32'hFFFF_FFFF, r, e);
        apb(SYSM_OFF_WIDTHS, 1'b0, 32'h0, r, e);
        chk("widths_rw", 32'h0FFF_0FFF, r);
        apb(12'h00C, 1'b1, 32'hFFFF_FFFF, r, e);
        apb(12'h00C, 1'b0, 32'h0, r, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, r);
        $display("test registers done");
        for (n = 0; n < 32; n++)
        begin
            c = 32'h0;
            c[10:8] = n[2:0];
            c[6] = n[3];
            c[11] = n[4];
            stream(c, 6);
        end
        for (n = 0; n < 8; n++)
        begin
            c = 32'h0;
            c[13:12] = n[1:0];
            c[11] = n[2];
            stream(c, 6);
        end
        stream(32'h0001_0020, 12);
        stream(32'h0000_0020, 8);
        stream(32'h0001_0000, 8);
        $display("test data path done");
        // generator off first: counters clear and widths are taken at once
        apb(SYSM_OFF_SETUP, 1'b1, 32'h0000_0000, r, e);
        apb(SYSM_OFF_TIMING, 1'b1, 32'h000F_0005, r, e);
        apb(SYSM_OFF_WIDTHS, 1'b1, 32'h0003_0001, r, e);
        apb(SYSM_OFF_SETUP, 1'b1, 32'h0001_0009, r, e);
        #1 chk("oe_n_out", 32'h4, {29'h0, pin_oe_n});
        measure(0, 1'b0, n);
        chk("line_width", 32'd4, 32'(n));
        measure(1, 1'b1, n);
        chk("frame_width", 32'd32, 32'(n));
        apb(SYSM_OFF_WIDTHS, 1'b1, 32'h0007_0002, r, e);
        apb(SYSM_OFF_SETUP, 1'b1, 32'h0001_0005, r, e);
        measure(1, 1'b0, n);
        chk("frame_width_new", 32'd48, 32'(n));
        measure(0, 1'b1, n);
        chk("line_width_new", 32'd8, 32'(n));
        // interlaced with field driven: status flips once per 96-clock frame
        apb(SYSM_OFF_SETUP, 1'b1, 32'h0001_0087, r, e);
        #1 chk("oe_n_field", 32'h0, {29'h0, pin_oe_n});
        apb(SYSM_OFF_SETUP, 1'b0, 32'h0, r, e);
        c = r;
        repeat (93) @(posedge pclk);
        apb(SYSM_OFF_SETUP, 1'b0, 32'h0, r, e);
        chk("field_toggle", {31'h0, ~c[15]}, {31'h0, r[15]});
        apb(SYSM_OFF_SETUP, 1'b1, 32'h0001_0000, r, e);
        #1 chk("oe_n_in", 32'h7, {29'h0, pin_oe_n});
        $display("test syncs done");
        print_verdict();
    end
endmodule
`default_nettype wire
